/* File: rtl/chm_tile.sv */
// configurable hard multiplier tile with an apb register front end
//
// Operation
// - tile runs as one wide multiplier or two concurrent narrow ones
// - wide mode takes operands up to eighteen bits, narrower ones too
// - a high sign select makes its operand two's complement, low unsigned
// - product signed when either operand is signed, else unsigned
// - one A sign select and one B sign select serve the tile
// - both narrow multipliers share the A and B sign selects
// - sign selects may change on any control write, acting on the operands already present
// - products keep full precision for every signedness mix
// - sign selects may be registered to align with registered operands
// - wide mode operands and result register or bypass independently
// - narrow operands and results register or bypass independently
// - all tile registers share one clock, enable and clear
// - five dynamic controls: two signs, clock, clock enable, clear
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "chm_cfg.svh"
module chm_tile
  import chm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output wire logic [31:0] prdata_out,
  output wire logic        pready_out,
  output wire logic        pslverr_out,
  // product from the tile, flopped once for the pin
  output wire logic [35:0] product_out
);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [`CHM_CTRL_W-1:0] ctrl_reg;
  logic [17:0]            opa_reg;
  logic [17:0]            opb_reg;
  logic [31:0]            prdata_reg;
  logic [35:0]            product_reg;

  wire logic access_w;
  wire logic wr_w;
  wire logic rd_w;
  wire logic hit_ctrl;
  wire logic hit_opa;
  wire logic hit_opb;
  wire logic hit_res;
  wire logic hit_stat;
  wire logic mapped_w;

  assign access_w = psel_in & penable_in;
  assign wr_w     = access_w & pwrite_in;
  assign rd_w     = access_w & ~pwrite_in;
  assign hit_ctrl = paddr_in == `CHM_OFF_CTRL;
  assign hit_opa  = paddr_in == `CHM_OFF_OPA;
  assign hit_opb  = paddr_in == `CHM_OFF_OPB;
  assign hit_res  = paddr_in == `CHM_OFF_RESULT;
  assign hit_stat = paddr_in == `CHM_OFF_STATUS;
  assign mapped_w = hit_ctrl | hit_opa | hit_opb | hit_res | hit_stat;

  // zero wait states; unmapped addresses and writes to read-only words error
  assign pready_out  = 1'b1;
  assign pslverr_out = access_w & (~mapped_w | (pwrite_in & (hit_res | hit_stat)));
  assign prdata_out  = prdata_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire logic [31:0] ctrl_m;
  wire logic [31:0] opa_m;
  wire logic [31:0] opb_m;
  assign ctrl_m = merge({21'h0, ctrl_reg}, pwdata_in, pstrb_in);
  assign opa_m  = merge({14'h0, opa_reg}, pwdata_in, pstrb_in);
  assign opb_m  = merge({14'h0, opb_reg}, pwdata_in, pstrb_in);

  // aclr is a self-clearing pulse so software need not write it twice
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `CHM_CTRL_RESET;
      opa_reg  <= 18'h0;
      opb_reg  <= 18'h0;
    end else begin
      if (wr_w && hit_ctrl) begin
        ctrl_reg <= ctrl_m[`CHM_CTRL_W-1:0];
      end else begin
        ctrl_reg[`CHM_CTRL_ACLR] <= 1'b0;
      end
      if (wr_w && hit_opa) begin
        opa_reg <= opa_m[17:0];
      end
      if (wr_w && hit_opb) begin
        opb_reg <= opb_m[17:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tile controls

  wire chm_mode_t mode_w;
  wire logic      signa_w;
  wire logic      signb_w;
  wire logic      clkena_w;
  wire logic      aclr_w;
  assign mode_w   = chm_mode_t'(ctrl_reg[`CHM_CTRL_MODE]);
  assign signa_w  = ctrl_reg[`CHM_CTRL_SIGNA];
  assign signb_w  = ctrl_reg[`CHM_CTRL_SIGNB];
  assign clkena_w = ctrl_reg[`CHM_CTRL_CLKENA];
  assign aclr_w   = ctrl_reg[`CHM_CTRL_ACLR];

  ////////////////////////////////////////////////////////////////////////////
  // input stage: low half feeds narrow 0, high half narrow 1, both halves the wide path

  wire logic [8:0]  a0_q;
  wire logic [8:0]  a1_q;
  wire logic [8:0]  b0_q;
  wire logic [8:0]  b1_q;
  wire logic        sa_q;
  wire logic        sb_q;
  wire logic        sa_reg_sel;
  wire logic        sb_reg_sel;
  wire logic        a1_reg_sel;
  wire logic        b1_reg_sel;

  // sign select takes the register when its a0/b0 operand half does, in both modes
  assign sa_reg_sel = ctrl_reg[`CHM_CTRL_REGA0];
  assign sb_reg_sel = ctrl_reg[`CHM_CTRL_REGB0];
  // a wide operand registers as one unit, so a half-registered operand cannot occur
  assign a1_reg_sel = (mode_w == CHM_MODE_NARROW) ? ctrl_reg[`CHM_CTRL_REGA1]
                                                  : ctrl_reg[`CHM_CTRL_REGA0];
  assign b1_reg_sel = (mode_w == CHM_MODE_NARROW) ? ctrl_reg[`CHM_CTRL_REGB1]
                                                  : ctrl_reg[`CHM_CTRL_REGB0];

  // every stage shares clk_in, clkena_w and aclr_w
  chm_stage #(.W(9)) u_a0 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(ctrl_reg[`CHM_CTRL_REGA0]), .d_in(opa_reg[8:0]), .q_out(a0_q)
  );
  chm_stage #(.W(9)) u_a1 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(a1_reg_sel), .d_in(opa_reg[17:9]), .q_out(a1_q)
  );
  chm_stage #(.W(9)) u_b0 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(ctrl_reg[`CHM_CTRL_REGB0]), .d_in(opb_reg[8:0]), .q_out(b0_q)
  );
  chm_stage #(.W(9)) u_b1 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(b1_reg_sel), .d_in(opb_reg[17:9]), .q_out(b1_q)
  );
  chm_stage #(.W(1)) u_sa (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(sa_reg_sel), .d_in(signa_w), .q_out(sa_q)
  );
  chm_stage #(.W(1)) u_sb (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(sb_reg_sel), .d_in(signb_w), .q_out(sb_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // multipliers

  wire logic [35:0] wide_p;
  wire logic [17:0] nar0_p;
  wire logic [17:0] nar1_p;

  // wide mode uses the a0/b0 register selects for the whole 18-bit operand;
  // narrower operands are simply sign- or zero-extended by the user
  chm_mult #(.W(`CHM_WIDE_W)) u_wide (
    .a_in({a1_q, a0_q}), .b_in({b1_q, b0_q}),
    .sign_a_in(sa_q), .sign_b_in(sb_q), .p_out(wide_p)
  );
  chm_mult #(.W(`CHM_NARROW_W)) u_nar0 (
    .a_in(a0_q), .b_in(b0_q), .sign_a_in(sa_q), .sign_b_in(sb_q), .p_out(nar0_p)
  );
  chm_mult #(.W(`CHM_NARROW_W)) u_nar1 (
    .a_in(a1_q), .b_in(b1_q), .sign_a_in(sa_q), .sign_b_in(sb_q), .p_out(nar1_p)
  );

  wire logic [35:0] prod_mux;
  assign prod_mux = (mode_w == CHM_MODE_NARROW) ? {nar1_p, nar0_p} : wide_p;

  ////////////////////////////////////////////////////////////////////////////
  // output stage, split so each narrow result registers on its own

  wire logic [17:0] res_lo;
  wire logic [17:0] res_hi;
  wire logic        hi_sel;
  // wide mode registers the whole product through the r0 select
  assign hi_sel = (mode_w == CHM_MODE_NARROW) ? ctrl_reg[`CHM_CTRL_REGR1]
                                              : ctrl_reg[`CHM_CTRL_REGR0];

  chm_stage #(.W(18)) u_r0 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(ctrl_reg[`CHM_CTRL_REGR0]), .d_in(prod_mux[17:0]), .q_out(res_lo)
  );
  chm_stage #(.W(18)) u_r1 (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clkena_in(clkena_w), .aclr_in(aclr_w),
    .use_reg_in(hi_sel), .d_in(prod_mux[35:18]), .q_out(res_hi)
  );

  // flop the product for the pin; reads see it a cycle behind the tile
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      product_reg <= 36'h0;
    end else begin
      product_reg <= {res_hi, res_lo};
    end
  end
  assign product_out = product_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  wire logic [31:0] rd_mux;
  wire logic        prod_signed;
  assign prod_signed = sa_q | sb_q;
  assign rd_mux = hit_ctrl ? {21'h0, ctrl_reg} :
                  hit_opa  ? {14'h0, opa_reg} :
                  hit_opb  ? {14'h0, opb_reg} :
                  hit_res  ? product_reg[31:0] :
                  hit_stat ? {25'h0, prod_signed, sb_q, sa_q, product_reg[35:32]} :
                             32'h0;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_reg <= 32'h0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_reg <= rd_mux;
    end
  end
endmodule

/* File: rtl/chm_cfg.svh */
// constants for the configurable hard multiplier tile
`ifndef CHM_CFG_SVH
`define CHM_CFG_SVH
`define CHM_WIDE_W      18
`define CHM_NARROW_W    9
`define CHM_PROD_W      36
`define CHM_HALF_W      18
// apb register byte offsets
`define CHM_OFF_CTRL    12'h000
`define CHM_OFF_OPA     12'h004
`define CHM_OFF_OPB     12'h008
`define CHM_OFF_RESULT  12'h00c
`define CHM_OFF_STATUS  12'h010
// control field positions
`define CHM_CTRL_MODE   0
`define CHM_CTRL_SIGNA  1
`define CHM_CTRL_SIGNB  2
`define CHM_CTRL_CLKENA 3
`define CHM_CTRL_ACLR   4
`define CHM_CTRL_REGA0  5
`define CHM_CTRL_REGB0  6
`define CHM_CTRL_REGA1  7
`define CHM_CTRL_REGB1  8
`define CHM_CTRL_REGR0  9
`define CHM_CTRL_REGR1  10
`define CHM_CTRL_W      11
`define CHM_CTRL_RESET  11'h008
`endif

/* File: rtl/chm_pkg.sv */
// types for the configurable hard multiplier tile
package chm_pkg;
  typedef enum logic [0:0] {
    CHM_MODE_WIDE   = 1'b0,
    CHM_MODE_NARROW = 1'b1
  } chm_mode_t;
endpackage

/* File: rtl/chm_stage.sv */
// optional register stage: tile clock enable, clear, bypass select
`timescale 1ns/100ps
`include "chm_cfg.svh"
module chm_stage
  import chm_pkg::*;
#(
  parameter int W = 18
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // tile controls
  input  wire logic         clkena_in,
  input  wire logic         aclr_in,
  input  wire logic         use_reg_in,
  // data
  input  wire logic [W-1:0] d_in,
  output wire logic [W-1:0] q_out
);
  logic [W-1:0] q_reg;
  // clear acts on the tile clock here, the bus reset being synchronous too
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || aclr_in) begin
      q_reg <= '0;
    end else if (clkena_in) begin
      q_reg <= d_in;
    end
  end
  assign q_out = use_reg_in ? q_reg : d_in;
endmodule

/* File: rtl/chm_mult.sv */
// full-precision multiplier with per-operand signedness
`timescale 1ns/100ps
`include "chm_cfg.svh"
module chm_mult
  import chm_pkg::*;
#(
  parameter int W = 18
) (
  // operands
  input  wire logic [W-1:0]   a_in,
  input  wire logic [W-1:0]   b_in,
  input  wire logic           sign_a_in,
  input  wire logic           sign_b_in,
  // product
  output wire logic [2*W-1:0] p_out
);
  // one extra bit makes signed and unsigned operands share one signed product
  wire logic signed [W:0]     a_ext;
  wire logic signed [W:0]     b_ext;
  wire logic signed [2*W+1:0] full;
  assign a_ext = {sign_a_in & a_in[W-1], a_in};
  assign b_ext = {sign_b_in & b_in[W-1], b_in};
  assign full  = a_ext * b_ext;
  assign p_out = full[2*W-1:0];
endmodule

/* File: testbench/chm_tile_props.sv */
// checker for the multiplier tile: products, stage timing, enable hold
`timescale 1ns/100ps
module chm_tile_props
  import chm_pkg::*;
(
  // clock, reset and apb request
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  // tile output
  input wire logic [35:0] product_out
);
  function automatic logic [35:0] ref_prod(input logic [10:0] c, input logic [17:0] a,
                                           input logic [17:0] b);
    logic signed [37:0] w;
    logic signed [19:0] n0;
    logic signed [19:0] n1;
    w  = $signed({c[1] & a[17], a}) * $signed({c[2] & b[17], b});
    n0 = $signed({c[1] & a[8], a[8:0]}) * $signed({c[2] & b[8], b[8:0]});
    n1 = $signed({c[1] & a[17], a[17:9]}) * $signed({c[2] & b[17], b[17:9]});
    return c[0] ? {n1[17:0], n0[17:0]} : w[35:0];
  endfunction
  ////////////////////////////////////////////////////////////////
  // shadow registers assume full byte strobes
  logic [10:0] ctl_reg;
  logic [17:0] a_reg;
  logic [17:0] b_reg;
  logic [3:0]  quiet_reg;
  wire         wr    = psel_in & penable_in & pwrite_in;
  wire         cw    = wr & (paddr_in == 12'h000);
  wire         opw   = wr & (paddr_in == 12'h004 | paddr_in == 12'h008);
  wire         stdy  = (quiet_reg > 4'h3) & ctl_reg[3];
  wire [35:0]  exp_w = ref_prod(ctl_reg, a_reg, b_reg);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl_reg   <= 11'h008;
      a_reg     <= 18'h00000;
      b_reg     <= 18'h00000;
      quiet_reg <= 4'h0;
    end else begin
      quiet_reg <= wr ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
      // the clear bit pulses once and reads back as zero
      if (cw) ctl_reg <= pwdata_in[10:0] & 11'h7ef;
      if (opw & ~paddr_in[3]) a_reg <= pwdata_in[17:0];
      if (opw & paddr_in[3]) b_reg <= pwdata_in[17:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_hold3;
    $stable(product_out)[*3];
  endsequence
  a_reset_zero: assert property (
    $rose(rst_n_in) |-> product_out == 36'h0) else $error("product not clear");
  a_wide_steady: assert property (
    stdy && !ctl_reg[0] |-> product_out == exp_w) else $error("wide product wrong");
  a_narrow_low: assert property (
    stdy && ctl_reg[0] |-> product_out[17:0] == exp_w[17:0]) else $error("narrow low wrong");
  a_narrow_high: assert property (
    stdy && ctl_reg[0] |-> product_out[35:18] == exp_w[35:18]) else $error("narrow high wrong");
  a_operand_bypass: assert property (
    opw && ctl_reg[10:3] == 8'h01 |-> ##2 product_out == exp_w) else $error("bypass path late");
  a_sign_dynamic: assert property (
    cw && pwdata_in[10:3] == 8'h01 |-> ##2 product_out == exp_w) else $error("sign change lost");
  a_stage_latency: assert property (
    opw && quiet_reg > 4'h3 && ctl_reg[10:3] == 8'hfd |-> ##1 s_hold3 ##1 product_out == exp_w)
    else $error("registered latency wrong");
  a_enable_hold: assert property (
    opw && quiet_reg > 4'h3 && ctl_reg[10:3] == 8'hfc |-> ##1 $stable(product_out)[*4])
    else $error("product moved with enable low");
endmodule
bind chm_tile chm_tile_props props_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .product_out(product_out));

/* File: testbench/chm_fabric.sv */
// fabric-side model: apb master feeding operands and fetching results
`timescale 1ns/100ps
module chm_fabric (
  // clock
  input  wire logic        clk_in,
  // apb master side
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out,
  output wire logic [3:0]  pstrb_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  // whole words only; byte lanes are left to the register front end
  assign pstrb_out = 4'hf;
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h0;
  end
  task automatic apb_xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= ad;
    pwdata_out  <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // released lines change so nothing can lean on stale values
    paddr_out   <= ~ad;
    pwdata_out  <= ~wd;
    @(posedge clk_in);
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the multiplier tile
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [10:0] ctrl;
    logic [17:0] opa;
    logic [17:0] opb;
  } chm_row_t;
  // every sign mix in both modes, boundary operands, some stages registered
  chm_row_t rows [10] = '{
    '{11'h008, 18'h3ffff, 18'h3ffff}, '{11'h00a, 18'h20000, 18'h3ffff},
    '{11'h00c, 18'h00003, 18'h20000}, '{11'h00e, 18'h20000, 18'h20000},
    '{11'h009, 18'h3ffff, 18'h3ffff}, '{11'h00b, 18'h3fd00, 18'h001ff},
    '{11'h00d, 18'h0a5c3, 18'h2f1ff}, '{11'h00f, 18'h20100, 18'h3fe01},
    '{11'h7ee, 18'h1ffff, 18'h3ffff}, '{11'h2ad, 18'h2aaaa, 18'h15555}};
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [31:0] rd_data;
  logic        err;
  logic [35:0] p;
  logic [10:0] c;
  int          num_errors  = 0;
  int          check_count = 0;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [3:0]  pstrb;
  wire  [35:0] product_out;
  chm_fabric fab_u (.clk_in(clk_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  chm_tile dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .product_out(product_out));
  initial forever #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // expected product: an operand gains a sign bit only when its select marks it signed
  function automatic logic [35:0] exp_prod(input logic [10:0] c, input logic [17:0] a,
                                           input logic [17:0] b);
    logic signed [37:0] w;
    logic signed [19:0] n0;
    logic signed [19:0] n1;
    w  = $signed({c[1] & a[17], a}) * $signed({c[2] & b[17], b});
    n0 = $signed({c[1] & a[8], a[8:0]}) * $signed({c[2] & b[8], b[8:0]});
    n1 = $signed({c[1] & a[17], a[17:9]}) * $signed({c[2] & b[17], b[17:9]});
    return c[0] ? {n1[17:0], n0[17:0]} : w[35:0];
  endfunction
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    fab_u.apb_xfer(1'b1, ad, d, rd_data, err);
  endtask
  task automatic rd(input logic [11:0] ad);
    fab_u.apb_xfer(1'b0, ad, 32'h0, rd_data, err);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(product_out, 36'h0);
    rd(12'h000);
    chk(rd_data, 36'h008);
    wr(12'h00c, 32'h1);
    chk(err, 36'h1);
    rd(12'h020);
    chk({3'h0, err, rd_data}, 36'h100000000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(12'h000, {21'h0, rows[i].ctrl});
      wr(12'h004, {14'h0, rows[i].opa});
      wr(12'h008, {14'h0, rows[i].opb});
      repeat (5) @(posedge clk_in);
      p = exp_prod(rows[i].ctrl, rows[i].opa, rows[i].opb);
      chk(product_out, p);
      rd(12'h00c);
      chk(rd_data, p[31:0]);
      rd(12'h010);
      c = rows[i].ctrl;
      chk(rd_data, {29'h0, c[1] | c[2], c[2], c[1], p[35:32]});
    end
    $display("test table done");
    wr(12'h004, 32'h3fd00);
    wr(12'h008, 32'h3fe01);
    for (int k = 0; k < 4; k++) begin
      c = {8'h01, k[1:0], 1'b0};
      wr(12'h000, {21'h0, c});
      #1;
      chk(product_out, exp_prod(c, 18'h3fd00, 18'h3fe01));
      @(posedge clk_in);
    end
    $display("test sign change done");
    wr(12'h000, 32'h7e0);
    repeat (4) @(posedge clk_in);
    p = exp_prod(11'h00e, 18'h3fd00, 18'h3fe01);
    chk(product_out, p);
    wr(12'h004, 32'h00155);
    repeat (4) @(posedge clk_in);
    chk(product_out, p);
    wr(12'h000, 32'h7e8);
    repeat (5) @(posedge clk_in);
    wr(12'h008, 32'h0007b);
    repeat (4) @(posedge clk_in);
    chk(product_out, exp_prod(11'h7e8, 18'h00155, 18'h0007b));
    wr(12'h000, 32'h7f8);
    rd(12'h000);
    chk(rd_data, 36'h7e8);
    // clear with the enable low: clear must still win and the product stay at zero
    wr(12'h000, 32'h7f0);
    repeat (3) @(posedge clk_in);
    chk(product_out, 36'h0);
    $display("test enable and clear done");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(product_out, 36'h0);
    rd(12'h000);
    chk(rd_data, 36'h008);
    $display("test mid reset done");
    finish_test();
  end
endmodule
